// File: rtl/boot_mode_pkg.sv
// Package with boot mode field layouts, divider encodings and register map
package boot_mode_pkg;
  // ****************************************
  // Boot mode field positions
  // ****************************************
  localparam int MODE_W = 32;
  localparam int SYS_DIV_LSB = 9;
  localparam int SYS_DIV_W = 4;
  localparam int CACHE_DIV_LSB = 19;
  localparam int CACHE_DIV_W = 3;
  localparam int POLICY_LSB = 22;
  localparam int POLICY_W = 3;
  localparam int DSD_BIT = 24;
  localparam int ECC_OFF_BIT = 22;
  localparam logic [2:0] POLICY_DSD_CODE = 3'h4;

  // ****************************************
  // Divider field codes, and divider values in half steps (value = 2 x divider)
  // ****************************************
  localparam logic [3:0] SYS_CODE_RSVD = 4'h0;
  localparam logic [3:0] SYS_CODE_FIRST = 4'h3;
  localparam logic [3:0] SYS_CODE_HALF_LAST = 4'hb;
  localparam logic [4:0] SYS_HALF_BASE = 5'h4;
  localparam logic [4:0] SYS_WHOLE_BASE = 5'he;
  localparam logic [3:0] SYS_CODE_WHOLE_FIRST = 4'hc;
  localparam logic [2:0] CACHE_CODE_X1 = 3'h1;
  localparam logic [2:0] CACHE_CODE_X15 = 3'h2;
  localparam logic [2:0] CACHE_CODE_X2 = 3'h3;
  localparam logic [2:0] CACHE_CODE_X25 = 3'h4;
  localparam logic [2:0] CACHE_CODE_X3 = 3'h5;
  localparam logic [2:0] CACHE_CODE_RSVD6 = 3'h6;
  localparam logic [2:0] CACHE_CODE_X4 = 3'h7;
  localparam logic [4:0] HALF_X15 = 5'h3;
  localparam logic [4:0] HALF_X2 = 5'h4;
  localparam logic [4:0] HALF_X25 = 5'h5;
  localparam logic [4:0] HALF_X3 = 5'h6;
  localparam logic [4:0] HALF_X4 = 5'h8;

  // ****************************************
  // Dirty-set timing
  // ****************************************
  localparam int DIRTY_SET_CYCLES = 10;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] CONFIG_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] DIVIDER_ADDR = 8'h08;
  localparam logic [7:0] FLAGS_ADDR = 8'h0c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Flags register bit positions
  localparam int FL_RSVD_SYS = 0;
  localparam int FL_RSVD_CACHE = 1;
  localparam int FL_RSVD_POLICY = 2;
  localparam int FL_TEST_CACHE = 3;
  localparam int FL_FALLBACK = 4;
  localparam int FL_DSD_ACTIVE = 5;

  typedef enum logic [1:0] {PRIV_KERNEL, PRIV_SUPER, PRIV_USER} priv_t;
  typedef enum {DS_IDLE, DS_WAIT, DS_SET} dirty_state_t;
endpackage

// File: rtl/boot_mode_latch.sv
// Reset-time capture of the boot mode word and its divider decode
`timescale 1ns/10ps
module boot_mode_latch
  import boot_mode_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [MODE_W-1:0] mode_sync,
  output logic [4:0] sys_half_reg,
  output logic [4:0] cache_half_reg,
  output logic dsd_reg,
  output logic rsvd_sys_reg,
  output logic rsvd_cache_reg,
  output logic rsvd_policy_reg,
  output logic test_cache_reg,
  output logic fallback_reg
);
  logic released_reg;
  wire [3:0] sys_code = mode_sync[SYS_DIV_LSB +: SYS_DIV_W];
  wire [2:0] cache_code = mode_sync[CACHE_DIV_LSB +: CACHE_DIV_W];
  wire [2:0] policy_code = mode_sync[POLICY_LSB +: POLICY_W];
  logic [4:0] sys_half_next;
  logic [4:0] cache_half_next;
  wire sys_fallback = (sys_code != SYS_CODE_RSVD) && (sys_code < SYS_CODE_FIRST);
  wire cache_fallback = (cache_code == CACHE_CODE_X1);

  always_comb begin
    // Half steps up to 6, then whole steps 7..10
    if (sys_code < SYS_CODE_FIRST) begin
      sys_half_next = SYS_HALF_BASE; // see R2
    end else if (sys_code <= SYS_CODE_HALF_LAST) begin
      sys_half_next = SYS_HALF_BASE + 5'(sys_code - SYS_CODE_FIRST); // see R1
    end else begin
      sys_half_next = SYS_WHOLE_BASE + 5'({sys_code - SYS_CODE_WHOLE_FIRST, 1'b0}); // see R1
    end
  end

  always_comb begin
    unique case (cache_code)
      CACHE_CODE_X2: cache_half_next = HALF_X2; // see R3
      CACHE_CODE_X25: cache_half_next = HALF_X25;
      CACHE_CODE_X3: cache_half_next = HALF_X3;
      CACHE_CODE_X4: cache_half_next = HALF_X4; // see R5
      default: cache_half_next = HALF_X15; // see R4
    endcase
  end

  // Hold the reset values live while in reset, freeze on the first edge after release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      released_reg <= 1'b0;
    end else begin
      released_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_half_reg <= SYS_HALF_BASE;
      cache_half_reg <= HALF_X15;
      dsd_reg <= 1'b0;
      rsvd_sys_reg <= 1'b0;
      rsvd_cache_reg <= 1'b0;
      rsvd_policy_reg <= 1'b0;
      test_cache_reg <= 1'b0;
      fallback_reg <= 1'b0;
    end else if (!released_reg) begin // see R16
      sys_half_reg <= sys_half_next;
      cache_half_reg <= cache_half_next;
      dsd_reg <= (policy_code == POLICY_DSD_CODE); // see R6
      rsvd_sys_reg <= (sys_code == SYS_CODE_RSVD);
      rsvd_cache_reg <= (cache_code == 3'h0) || (cache_code == CACHE_CODE_RSVD6); // see R4
      rsvd_policy_reg <= (policy_code != POLICY_DSD_CODE) && (policy_code != 3'h0);
      test_cache_reg <= (cache_code == CACHE_CODE_X4); // see R5
      fallback_reg <= sys_fallback || cache_fallback;
    end
  end
endmodule

// File: rtl/boot_mode_decode_dsd.sv
// Boot mode decoder with delay-speculative-dirty policy and AXI4-Lite registers
//
// Behaviour
// R1 - System divider codes 3..15 give 2..10
// R2 - Codes 1,2 fall back to divide two
// R3 - Cache divider codes give 1.5 to 4
// R4 - Cache code 1 falls back to 1.5
// R5 - Cache divide-by-four is a test setting
// R6 - Only policy code 100 selects delayed dirty
// R7 - Mode bit 24 shows in config bit 24; the code sets config bit 24 for policy code 100 only
// R8 - User mode enables policy via status bit
// R9 - Config bit 24 is read-only
// R10 - Dirty set waits for oldest store
// R11 - Dirty set costs ten cycles, once per refill
// R12 - Young store miss refills clean exclusive
// R13 - Store hit on shared upgrades immediately
// R14 - Non-coherent cached load waits until oldest
// R15 - Config bit 22 disables cache correction
// R16 - Selections captured at reset, then held
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
module boot_mode_decode_dsd
  import boot_mode_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RSTN,
  // Boot mode pins
  input wire logic [MODE_W-1:0] MODE_BITS,
  // Privilege and pipeline events
  input wire logic [1:0] PRIV_MODE,
  input wire logic STORE_REQ,
  input wire logic STORE_OLDEST,
  input wire logic LINE_DIRTY,
  input wire logic LINE_SHARED,
  input wire logic CACHE_MISS,
  input wire logic REFILL_DONE,
  input wire logic LOAD_REQ,
  input wire logic LOAD_NONCOH,
  input wire logic LOAD_OLDEST,
  // Cache control outputs
  output logic SET_DIRTY,
  output logic DIRTY_BUSY,
  output logic REFILL_CLEAN_EXCL,
  output logic UPGRADE_CLEAN_EXCL,
  output logic LOAD_GO,
  output logic ECC_CORRECT_OFF,
  output logic DSD_ACTIVE,
  output logic [4:0] SYS_DIV_HALF,
  output logic [4:0] CACHE_DIV_HALF,
  // AXI4-Lite slave
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [MODE_W-1:0] mode_meta_reg;
  logic [MODE_W-1:0] mode_sync_reg;
  // No reset: pins must flow through while reset is held, or capture sees zeros
  always_ff @(posedge MCLK) begin
    mode_meta_reg <= MODE_BITS;
    mode_sync_reg <= mode_meta_reg; // see R16
  end

  // ****************************************
  // Boot capture
  // ****************************************
  logic [4:0] sys_half_reg;
  logic [4:0] cache_half_reg;
  logic dsd_boot_reg;
  logic rsvd_sys_reg;
  logic rsvd_cache_reg;
  logic rsvd_policy_reg;
  logic test_cache_reg;
  logic fallback_reg;
  boot_mode_latch u_latch (
    .clk(MCLK),
    .rst_n(RSTN),
    .mode_sync(mode_sync_reg),
    .sys_half_reg(sys_half_reg),
    .cache_half_reg(cache_half_reg),
    .dsd_reg(dsd_boot_reg),
    .rsvd_sys_reg(rsvd_sys_reg),
    .rsvd_cache_reg(rsvd_cache_reg),
    .rsvd_policy_reg(rsvd_policy_reg),
    .test_cache_reg(test_cache_reg),
    .fallback_reg(fallback_reg)
  );

  // ****************************************
  // Software registers
  // ****************************************
  logic ecc_off_reg;
  logic user_dsd_reg;
  wire [31:0] config_word = (32'(dsd_boot_reg) << DSD_BIT) | (32'(ecc_off_reg) << ECC_OFF_BIT); // see R7
  wire [31:0] status_word = 32'(user_dsd_reg) << DSD_BIT;
  wire [31:0] divider_word = {19'h0, cache_half_reg, 3'h0, sys_half_reg};
  wire [31:0] flags_word = {26'h0, DSD_ACTIVE, fallback_reg, test_cache_reg,
    rsvd_policy_reg, rsvd_cache_reg, rsvd_sys_reg};

  // ****************************************
  // Policy selection
  // ****************************************
  wire priv_user = (PRIV_MODE == PRIV_USER);
  wire dsd_now = priv_user ? user_dsd_reg : dsd_boot_reg; // see R7 R8

  // ****************************************
  // Delayed dirty sequencer
  // ****************************************
  dirty_state_t ds_reg;
  dirty_state_t ds_next;
  logic [3:0] ds_cnt_reg;
  logic refilled_reg;
  wire store_clean = STORE_REQ && !LINE_DIRTY && !CACHE_MISS;
  wire need_wait = store_clean && dsd_now && refilled_reg;
  always_comb begin
    ds_next = ds_reg;
    unique case (ds_reg)
      DS_IDLE: if (need_wait) ds_next = STORE_OLDEST ? DS_SET : DS_WAIT; // see R10
      DS_WAIT: if (STORE_OLDEST) ds_next = DS_SET; // see R10
      DS_SET: if (ds_cnt_reg == 4'(DIRTY_SET_CYCLES - 1)) ds_next = DS_IDLE; // see R11
    endcase
  end
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ds_reg <= DS_IDLE;
      ds_cnt_reg <= 4'h0;
    end else begin
      ds_reg <= ds_next;
      ds_cnt_reg <= (ds_reg == DS_SET) ? ds_cnt_reg + 4'h1 : 4'h0;
    end
  end
  // Cost is paid once per refill; later clean stores to the same block stay fast
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      refilled_reg <= 1'b0;
    end else if (REFILL_DONE) begin
      refilled_reg <= 1'b1; // see R11
    end else if (ds_reg == DS_SET && ds_next == DS_IDLE) begin
      refilled_reg <= 1'b0;
    end
  end

  // ****************************************
  // Cache control outputs
  // ****************************************
  wire set_dirty_next = (ds_reg == DS_SET && ds_next == DS_IDLE)
    || (store_clean && !need_wait && ds_reg == DS_IDLE && (!dsd_now || STORE_OLDEST)); // see R10 R11
  wire refill_ce_next = CACHE_MISS && STORE_REQ && dsd_now && !STORE_OLDEST; // see R12
  wire upgrade_next = STORE_REQ && LINE_SHARED && !CACHE_MISS; // see R13
  wire load_go_next = LOAD_REQ && (!LOAD_NONCOH || LOAD_OLDEST); // see R14
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      SET_DIRTY <= 1'b0;
      DIRTY_BUSY <= 1'b0;
      REFILL_CLEAN_EXCL <= 1'b0;
      UPGRADE_CLEAN_EXCL <= 1'b0;
      LOAD_GO <= 1'b0;
      ECC_CORRECT_OFF <= 1'b0;
      DSD_ACTIVE <= 1'b0;
      SYS_DIV_HALF <= SYS_HALF_BASE;
      CACHE_DIV_HALF <= HALF_X15;
    end else begin
      SET_DIRTY <= set_dirty_next;
      DIRTY_BUSY <= (ds_next != DS_IDLE);
      REFILL_CLEAN_EXCL <= refill_ce_next;
      UPGRADE_CLEAN_EXCL <= upgrade_next;
      LOAD_GO <= load_go_next;
      ECC_CORRECT_OFF <= ecc_off_reg; // see R15
      DSD_ACTIVE <= dsd_now;
      SYS_DIV_HALF <= sys_half_reg;
      CACHE_DIV_HALF <= cache_half_reg;
    end
  end

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  wire aw_take = AWVALID && AWREADY;
  wire w_take = WVALID && WREADY;
  wire wr_fire = aw_held_reg && w_held_reg && !BVALID;
  wire wr_config = (aw_addr_reg == CONFIG_ADDR);
  wire wr_status = (aw_addr_reg == STATUS_ADDR);
  wire wr_ok = wr_config || wr_status || (aw_addr_reg == DIVIDER_ADDR) || (aw_addr_reg == FLAGS_ADDR);
  wire lane_ecc = w_strb_reg[ECC_OFF_BIT / 8];
  wire lane_dsd = w_strb_reg[DSD_BIT / 8];
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= AWADDR;
        AWREADY <= 1'b0;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        w_data_reg <= WDATA;
        w_strb_reg <= WSTRB;
        WREADY <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end
  // Config bit 24 has no write path; only bit 22 is writable there
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ecc_off_reg <= 1'b0;
      user_dsd_reg <= 1'b0;
    end else if (wr_fire) begin
      if (wr_config && lane_ecc) ecc_off_reg <= w_data_reg[ECC_OFF_BIT]; // see R9 R15
      if (wr_status && lane_dsd) user_dsd_reg <= w_data_reg[DSD_BIT]; // see R8
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  logic [31:0] rd_word;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    unique case (ARADDR)
      CONFIG_ADDR: rd_word = config_word;
      STATUS_ADDR: rd_word = status_word;
      DIVIDER_ADDR: rd_word = divider_word;
      FLAGS_ADDR: rd_word = flags_word;
      default: begin
        rd_word = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h0;
      RRESP <= RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RDATA <= rd_word;
      RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  logic [7:0] age_reg;
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) age_reg <= 8'h0;
    else if (age_reg != 8'hff) age_reg <= age_reg + 8'h1;
  end
  divider_held_a: assert property (age_reg > 8'h4 |-> $stable(SYS_DIV_HALF) && $stable(CACHE_DIV_HALF)) // see R16
    else $error("divider changed after boot");
  sys_range_a: assert property (SYS_DIV_HALF >= 5'h4 && SYS_DIV_HALF <= 5'h14) // see R1 R2
    else $error("system divider out of range");
  cache_range_a: assert property (CACHE_DIV_HALF >= HALF_X15 && CACHE_DIV_HALF <= HALF_X4) // see R3 R4
    else $error("cache divider out of range");
  config_ro_a: assert property (age_reg > 8'h4 |-> $stable(config_word[DSD_BIT])) // see R9
    else $error("config policy bit changed");
  policy_sel_a: assert property (DSD_ACTIVE == $past(dsd_now)) // see R7 R8
    else $error("policy selection wrong");
  dirty_wait_a: assert property (ds_reg == DS_WAIT && !STORE_OLDEST |=> !SET_DIRTY) // see R10
    else $error("dirty set before oldest");
  dirty_cost_a: assert property (ds_reg != DS_SET && ds_next == DS_SET // see R11
    |=> (ds_reg == DS_SET)[*8] ##1 ds_reg == DS_SET ##1 ds_reg == DS_SET ##1 SET_DIRTY)
    else $error("dirty cost not ten cycles");
  young_dirty_a: assert property (STORE_REQ && dsd_now && !STORE_OLDEST && ds_reg != DS_SET // see R10
    |=> !SET_DIRTY)
    else $error("young store set dirty");
  refill_ce_a: assert property (CACHE_MISS && STORE_REQ && dsd_now && !STORE_OLDEST |=> REFILL_CLEAN_EXCL) // see R12
    else $error("young store miss not clean exclusive");
  upgrade_a: assert property (STORE_REQ && LINE_SHARED && !CACHE_MISS |=> UPGRADE_CLEAN_EXCL) // see R13
    else $error("shared hit not upgraded");
  load_hold_a: assert property (LOAD_REQ && LOAD_NONCOH && !LOAD_OLDEST |=> !LOAD_GO) // see R14
    else $error("non-coherent load issued early");
  ecc_off_a: assert property (ECC_CORRECT_OFF == $past(config_word[ECC_OFF_BIT])) // see R15
    else $error("correction disable not followed");
  cov_dirty_c: cover property (ds_reg == DS_WAIT ##[1:20] SET_DIRTY);
  cov_refill_c: cover property (REFILL_CLEAN_EXCL);
  cov_user_c: cover property (priv_user && DSD_ACTIVE);
  cov_write_c: cover property (BVALID && BREADY);
endmodule

// File: dv/boot_mode_source.sv
// Model of the board logic that drives the boot mode pins
`timescale 1ns/10ps
module boot_mode_source
  import boot_mode_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Requested settings
  input wire logic [3:0] sys_code,
  input wire logic [2:0] cache_code,
  input wire logic dsd_on,
  // Boot mode pins
  output logic [MODE_W-1:0] mode_bits = '0
);
  logic [MODE_W-1:0] word;

  always_comb begin
    word = '0;
    word[SYS_DIV_LSB +: SYS_DIV_W] = sys_code;
    word[CACHE_DIV_LSB +: CACHE_DIV_W] = cache_code;
    // Off goes out as zero, which the decoder reads as policy off
    word[POLICY_LSB +: POLICY_W] = dsd_on ? POLICY_DSD_CODE : 3'h0;
  end

  // Pins move only under reset, so they are long settled at release
  always @(posedge clk) begin
    if (!rst_n) begin
      mode_bits <= word;
    end
  end
endmodule

// File: dv/boot_mode_decode_dsd_bench.sv
// Self-checking bench for the boot mode decoder
`timescale 1ns/10ps
module boot_mode_decode_dsd_bench;
  import boot_mode_pkg::*;
  logic MCLK, RSTN, AWVALID, WVALID, BREADY, ARVALID, RREADY, dsd_on;
  logic [1:0] PRIV_MODE, BRESP, RRESP;
  logic [8:0] ev;
  logic [31:0] MODE_BITS, WDATA, RDATA, d;
  logic [7:0] AWADDR, ARADDR;
  logic [3:0] WSTRB, sys_code;
  logic [2:0] cache_code;
  logic [4:0] SYS_DIV_HALF, CACHE_DIV_HALF;
  logic SET_DIRTY, DIRTY_BUSY, REFILL_CLEAN_EXCL, UPGRADE_CLEAN_EXCL, LOAD_GO, ECC_CORRECT_OFF, DSD_ACTIVE;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0] r;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [2:0] cc [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
  logic [4:0] ch [6] = '{5'h3, 5'h3, 5'h4, 5'h5, 5'h6, 5'h8};

  boot_mode_source src (.clk(MCLK), .rst_n(RSTN), .sys_code(sys_code), .cache_code(cache_code),
    .dsd_on(dsd_on), .mode_bits(MODE_BITS));

  boot_mode_decode_dsd dut (.MCLK(MCLK), .RSTN(RSTN), .MODE_BITS(MODE_BITS), .PRIV_MODE(PRIV_MODE),
    .STORE_REQ(ev[0]), .STORE_OLDEST(ev[1]), .LINE_DIRTY(ev[2]), .LINE_SHARED(ev[3]),
    .CACHE_MISS(ev[4]), .REFILL_DONE(ev[8]), .LOAD_REQ(ev[5]), .LOAD_NONCOH(ev[6]),
    .LOAD_OLDEST(ev[7]), .SET_DIRTY(SET_DIRTY), .DIRTY_BUSY(DIRTY_BUSY),
    .REFILL_CLEAN_EXCL(REFILL_CLEAN_EXCL), .UPGRADE_CLEAN_EXCL(UPGRADE_CLEAN_EXCL),
    .LOAD_GO(LOAD_GO), .ECC_CORRECT_OFF(ECC_CORRECT_OFF), .DSD_ACTIVE(DSD_ACTIVE),
    .SYS_DIV_HALF(SYS_DIV_HALF), .CACHE_DIV_HALF(CACHE_DIV_HALF), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY));

  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic test_done;
    if (errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t %s got %h expected %h", $time, m, g, e);
    end
  endtask

  task automatic do_reset(input logic [3:0] s, input logic [2:0] c, input logic p);
    @(posedge MCLK);
    sys_code <= s;
    cache_code <= c;
    dsd_on <= p;
    RSTN <= 1'b0;
    ev <= '0;
    PRIV_MODE <= 2'h0;
    repeat (6) @(posedge MCLK);
    RSTN <= 1'b1;
    repeat (3) @(posedge MCLK);
    #1;
  endtask

  // Drive one cycle of pipeline events; registered answers are settled on return
  task automatic step(input logic [8:0] v);
    @(posedge MCLK);
    ev <= v;
    @(posedge MCLK);
    ev <= '0;
    #1;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rsp);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    rsp = 2'h1;
    @(posedge MCLK);
    AWADDR <= a;
    WDATA <= dat;
    WSTRB <= 4'hf;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    forever begin
      @(posedge MCLK);
      if (aw && AWREADY === 1'b1) begin
        aw = 1'b0;
        AWVALID <= 1'b0;
      end
      if (w && WREADY === 1'b1) begin
        w = 1'b0;
        WVALID <= 1'b0;
      end
      if (BVALID === 1'b1) begin
        rsp = BRESP;
        BREADY <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rsp);
    logic ar;
    ar = 1'b1;
    rsp = 2'h1;
    dat = 'x;
    @(posedge MCLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    forever begin
      @(posedge MCLK);
      if (ar && ARREADY === 1'b1) begin
        ar = 1'b0;
        ARVALID <= 1'b0;
      end
      if (RVALID === 1'b1) begin
        dat = RDATA;
        rsp = RRESP;
        RREADY <= 1'b0;
        break;
      end
    end
  endtask

  function automatic logic [4:0] sys_exp(input logic [3:0] c);
    if (c < 4'h3) return 5'h4;
    if (c <= 4'hb) return {1'b0, c} + 5'h1;
    return {1'b0, c} + {1'b0, c} - 5'ha;
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_dividers;
    int k;
    for (int i = 1; i < 16; i++) begin
      k = i % 6;
      do_reset(i[3:0], cc[k], 1'b0);
      chk(SYS_DIV_HALF, sys_exp(i[3:0]), "system divider");
      chk(CACHE_DIV_HALF, ch[k], "cache divider");
      axi_rd(FLAGS_ADDR, d, r);
      chk(d[FL_TEST_CACHE], cc[k] == 3'h7, "test divider flag");
      chk(d[FL_FALLBACK], i < 3 || k == 0, "fallback flag");
      #1;
      chk(SYS_DIV_HALF, sys_exp(i[3:0]), "divider held");
    end
  endtask

  task automatic t_config;
    do_reset(4'h3, 3'h2, 1'b1);
    chk(DSD_ACTIVE, 1'b1, "kernel policy");
    axi_wr(CONFIG_ADDR, 32'h00400000, r);
    chk(r, RESP_OKAY, "config write");
    axi_rd(CONFIG_ADDR, d, r);
    chk(d[24], 1'b1, "config bit kept");
    chk(d[22], 1'b1, "correction off bit");
    #1;
    chk(ECC_CORRECT_OFF, 1'b1, "correction off");
    PRIV_MODE <= 2'h2;
    repeat (3) @(posedge MCLK);
    #1;
    chk(DSD_ACTIVE, 1'b0, "user policy off");
    axi_wr(STATUS_ADDR, 32'h01000000, r);
    chk(r, RESP_OKAY, "status write");
    repeat (3) @(posedge MCLK);
    #1;
    chk(DSD_ACTIVE, 1'b1, "user policy on");
    axi_wr(CONFIG_ADDR, 32'h0, r);
    repeat (3) @(posedge MCLK);
    #1;
    chk(ECC_CORRECT_OFF, 1'b0, "correction on");
    axi_wr(8'h10, 32'h1, r);
    chk(r, RESP_SLVERR, "unmapped write");
    axi_rd(8'h14, d, r);
    chk(r, RESP_SLVERR, "unmapped read");
  endtask

  task automatic t_speculative;
    do_reset(4'h3, 3'h2, 1'b1);
    step(9'h011);
    chk(REFILL_CLEAN_EXCL, 1'b1, "young miss");
    do_reset(4'h3, 3'h2, 1'b1);
    step(9'h009);
    chk(UPGRADE_CLEAN_EXCL, 1'b1, "shared upgrade");
    do_reset(4'h3, 3'h2, 1'b1);
    step(9'h100);
    step(9'h001);
    for (int n = 0; n < 6; n++) begin
      chk({DIRTY_BUSY, SET_DIRTY}, 2'h2, "dirty held back");
      @(posedge MCLK);
      #1;
    end
    @(posedge MCLK);
    ev <= 9'h002;
    for (int n = 1; n <= 30; n++) begin
      @(posedge MCLK);
      #1;
      if (SET_DIRTY === 1'b1 || n == 30) begin
        chk(n >= 10 && n <= 13, 1'b1, "dirty set delay");
        break;
      end
    end
    ev <= '0;
    step(9'h003);
    chk({DIRTY_BUSY, SET_DIRTY}, 2'h1, "second store direct");
  endtask

  task automatic t_policy_off;
    do_reset(4'h3, 3'h2, 1'b0);
    chk(DSD_ACTIVE, 1'b0, "policy off");
    axi_rd(CONFIG_ADDR, d, r);
    chk(d[24], 1'b0, "config bit clear");
    step(9'h011);
    chk(REFILL_CLEAN_EXCL, 1'b0, "miss without policy");
    step(9'h001);
    chk(SET_DIRTY, 1'b1, "dirty set at once");
    step(9'h060);
    chk(LOAD_GO, 1'b0, "non-coherent young load");
    step(9'h0e0);
    chk(LOAD_GO, 1'b1, "non-coherent oldest load");
    step(9'h020);
    chk(LOAD_GO, 1'b1, "coherent young load");
  endtask

  // Generous ceiling: the run needs well under two thousand cycles
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      $display("BAD %0t timeout", $time);
      test_done;
    end
  end

  initial begin
    RSTN = 1'b0;
    ev = '0;
    PRIV_MODE = 2'h0;
    sys_code = 4'h3;
    cache_code = 3'h2;
    dsd_on = 1'b0;
    AWADDR = '0;
    AWVALID = 1'b0;
    WDATA = '0;
    WSTRB = 4'hf;
    WVALID = 1'b0;
    BREADY = 1'b0;
    ARADDR = '0;
    ARVALID = 1'b0;
    RREADY = 1'b0;
    t_dividers;
    t_config;
    t_speculative;
    t_policy_off;
    test_done;
  end
endmodule
